// File: verification/isc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// core and mover stand-in: acks each offer once, answers table reads
module isc_core_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       svc_req,
  input  wire logic       vt_rd,
  input  wire logic       xfer_req,
  output logic            svc_ack,
  output logic [7:0]      vt_data,
  output logic            xfer_done
);
  logic xfer_seen;
  // table byte toggles when not read, so stale data cannot pass
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      svc_ack   <= 1'b0;
      vt_data   <= 8'h00;
      xfer_seen <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      svc_ack   <= svc_req & ~svc_ack;
      vt_data   <= vt_rd ? 8'hF5 : ~vt_data;
      xfer_seen <= xfer_req & ~xfer_done;
      xfer_done <= xfer_seen & xfer_req & ~xfer_done;
    end
  end
endmodule : isc_core_model
`default_nettype wire

// File: verification/isc_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// watches the core-side handshakes of the service controller
module isc_ctrl_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        svc_req,
  input wire logic        svc_ack,
  input wire logic [15:0] svc_vector,
  input wire logic        svc_ctx_switch,
  input wire logic [2:0]  svc_bank,
  input wire logic        vt_rd,
  input wire logic [7:0]  vt_data,
  input wire logic        core_hold,
  input wire logic        xfer_req,
  input wire logic        xfer_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // offers stand still until taken, then go away at once
  reset_vec_a: assert property (
    $rose(rst_n) |=> svc_req && svc_vector == 16'h0000 && !svc_ctx_switch)
    else $error("reset vector not offered first");
  ack_drop_a: assert property (svc_req && svc_ack |=> !svc_req)
    else $error("offer stays after ack");
  offer_hold_a: assert property (
    svc_req && !svc_ack |=> svc_req && $stable(svc_vector))
    else $error("offer changed before ack");
  bank_load_a: assert property (
    $rose(vt_rd) |-> ##2 svc_req && svc_ctx_switch
      && {5'h00, svc_bank} == ($past(vt_data) & 8'h07))
    else $error("bank not taken from table byte");
  core_stop_a: assert property (xfer_req |-> core_hold)
    else $error("core runs during transfer");
  xfer_wait_a: assert property (xfer_req && !xfer_done |=> xfer_req)
    else $error("transfer request dropped early");
  resume_a: assert property (
    xfer_done && xfer_req |=> !xfer_req ##1 !core_hold)
    else $error("core not resumed after transfer");
  macro_quiet_a: assert property (core_hold |-> !svc_req)
    else $error("vector offered during macro");
endmodule : isc_ctrl_monitor
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk, rst_n, wr, rd, ie, svc_req, svc_ack, svc_ctx_switch;
  logic        core_hold, vt_rd, xfer_req, xfer_done, restore_req, xfer_wide;
  logic [7:0]  addr, wdata, rdata, vt_data;
  logic [28:0] pl;
  logic [15:0] svc_vector, vt_addr;
  logic [2:0]  svc_bank, restore_bank;
  logic [4:0]  xfer_idx;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          fb[4] = '{12, 13, 10, 11};
  logic [15:0] fv[4] = '{16'h0002, 16'h0004, 16'h003E, 16'h003C};
  int          ct[12] = '{0, 5, 6, 7, 8, 13, 14, 15, 16, 17, 1, 7};
  int          bt[12] = '{0, 19, 20, 21, 1, 6, 7, 14, 15, 8, 22, 28};
  isc_ctrl isc_ctrl_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .nmi_pin(pl[12]), .ext_pin_irq(pl[28:22]), .timer_event_input(pl[21]),
    .watchdog_irq(pl[13]), .timer0_overflow_irq(pl[0]),
    .capture_x0_match_irq(pl[19]), .capture_01_match_irq(pl[20]),
    .compare_match_irq(pl[6:1]), .uart_rx_done_irq(pl[7]),
    .uart_tx_done_irq(pl[14]), .sync_serial_done_irq(pl[15]),
    .converter_done_irq(pl[8]), .uart_rx_error_signal(pl[9]),
    .core_int_enable(ie), .software_break_instr(pl[10]),
    .opcode_trap(pl[11]), .bank_switch_trap_instr(pl[16]),
    .bank_trap_imm(3'h6), .bank_return_instr(pl[17]),
    .bank_trap_return_instr(pl[18]), .svc_ack, .svc_req, .svc_vector,
    .svc_ctx_switch, .svc_bank, .core_hold, .restore_req,
    .restore_bank, .vt_rd, .vt_addr, .vt_data, .xfer_done, .xfer_req,
    .xfer_idx, .xfer_wide);
  isc_core_model isc_core_model_inst (.clk, .rst_n, .svc_req, .vt_rd,
    .xfer_req, .svc_ack, .vt_data, .xfer_done);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cut a hang short; the run needs far fewer cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      complete_run();
    end
  end
  function automatic logic [15:0] vec(input int i);
    return (i < 14) ? 16'(6 + 2 * i) : 16'(36 + 2 * (i - 14));
  endfunction : vec
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic pulse(input logic [28:0] m);
    @(posedge clk);
    pl <= m;
    @(posedge clk);
    pl <= 29'h0000000;
  endtask : pulse
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : rd_chk
  // c[3] set means a bank switch into bank c[2:0] is expected
  task automatic get_svc(input logic [15:0] v, input logic [3:0] c);
    int n;
    n = 0;
    while (svc_req !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("request", 16'h0001, {15'h0000, svc_req});
    if (!c[3]) chk("vector", v, svc_vector);
    chk("switch", {12'h000, c},
        {12'h000, svc_ctx_switch, c[3] ? svc_bank : 3'h0});
    while (svc_req === 1'b1) @(negedge clk);
  endtask : get_svc
  task automatic quiet();
    repeat (10) @(negedge clk);
    chk("idle", 16'h0000, {15'h0000, svc_req});
  endtask : quiet
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic test_fixed();
    get_svc(16'h0000, 4'h0);
    for (int i = 0; i < 4; i++) begin
      pulse(29'h0000001 << fb[i]);
      get_svc(fv[i], 4'h0);
    end
    $display("test fixed sources done");
  endtask : test_fixed
  task automatic test_vectors();
    pulse(29'h0000201);
    quiet();
    rd_chk(8'h00, 8'h23);
    rd_chk(8'h60, 8'h20);
    wr_reg(8'h00, 8'h21);
    quiet();
    @(posedge clk);
    ie <= 1'b1;
    get_svc(16'h0006, 4'h0);
    for (int i = 0; i < 12; i++) begin
      wr_reg(8'(ct[i]), 8'h20);
      pulse(29'h0000001 << bt[i]);
      get_svc(vec(ct[i]), 4'h0);
    end
    $display("test vectors done");
  endtask : test_vectors
  task automatic test_banks();
    wr_reg(8'h09, 8'h00);
    pulse(29'h0000046);
    get_svc(16'h0018, 4'h0);
    get_svc(16'h0016, 4'h0);
    get_svc(16'h0020, 4'h0);
    wr_reg(8'h00, 8'h28);
    pulse(29'h0000001);
    get_svc(16'h0000, 4'hD);
    chk("table", 16'h0006, vt_addr);
    pulse(29'h0010000);
    get_svc(16'h0000, 4'hE);
    pulse(29'h0040000);
    @(negedge clk);
    chk("restore", 16'h000E, {12'h000, restore_req, restore_bank});
    pulse(29'h0020000);
    @(negedge clk);
    chk("restore", 16'h000D, {12'h000, restore_req, restore_bank});
    $display("test priority and banks done");
  endtask : test_banks
  task automatic test_macro();
    wr_reg(8'h31, 8'h02);
    wr_reg(8'h11, 8'h64);
    pulse(29'h0000100);
    repeat (12) @(negedge clk);
    chk("xfer", 16'h0031, {10'h000, xfer_wide, xfer_idx});
    rd_chk(8'h11, 8'h64);
    rd_chk(8'h31, 8'h01);
    pulse(29'h0000100);
    get_svc(16'h002A, 4'h0);
    $display("test macro done");
  endtask : test_macro
  initial begin
    {rst_n, wr, rd, ie} = 4'h0;
    {addr, wdata} = 16'h0000;
    pl = 29'h0000000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    test_fixed();
    test_vectors();
    test_banks();
    test_macro();
    complete_run();
  end
endmodule : tb
bind isc_ctrl isc_ctrl_monitor isc_ctrl_monitor_inst (.clk, .rst_n,
  .svc_req, .svc_ack, .svc_vector, .svc_ctx_switch, .svc_bank, .vt_rd,
  .vt_data, .core_hold, .xfer_req, .xfer_done);
`default_nettype wire

// File: verilog/isc_ctrl.sv
// Operation
// - masked source stays pending, never serviced
// - vectored requests wait while interrupts disabled
// - context switch disabled gives normal vector branch
// - context switch enabled selects bank switching
// - macro mode source goes to hardware macro
// - break vectors 003EH, opcode trap 003CH
// - pin nmi 0002H, watchdog 0004H, unmaskable
// - fixed priorities 0..17, vectors 0006H..002AH
// - priorities 5,6,7 shared pin/timer sources
// - serial sources at 0024H, 0026H, 0028H
// - receive error is status only, no vector
// - core held while macro service runs
// - macro moves one or two bytes
// - macro end clears flag, core resumes
// - count exhausted turns into vectored request
// - switch by interrupt or trap instruction
// - core loads bank vector, saves pc/psw
// - interrupt bank from vector entry low bits
// - trap bank from immediate, own return
// - bank return restores from saved bank
// - four programmable priority levels
`timescale 1ns/100ps
`default_nettype none
module isc_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // register port
  input  wire logic [isc_pkg::ADDR_W-1:0] addr,
  input  wire logic [isc_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [isc_pkg::DATA_W-1:0]      rdata,
  // asynchronous pins
  input  wire logic                       nmi_pin,
  input  wire logic [6:0]                 ext_pin_irq,
  input  wire logic                       timer_event_input,
  // on-chip sources, same clock
  input  wire logic                       watchdog_irq,
  input  wire logic                       timer0_overflow_irq,
  input  wire logic                       capture_x0_match_irq,
  input  wire logic                       capture_01_match_irq,
  input  wire logic [5:0]                 compare_match_irq,
  input  wire logic                       uart_rx_done_irq,
  input  wire logic                       uart_tx_done_irq,
  input  wire logic                       sync_serial_done_irq,
  input  wire logic                       converter_done_irq,
  input  wire logic                       uart_rx_error_signal,
  // core side
  input  wire logic                       core_int_enable,
  input  wire logic                       software_break_instr,
  input  wire logic                       opcode_trap,
  input  wire logic                       bank_switch_trap_instr,
  input  wire logic [2:0]                 bank_trap_imm,
  input  wire logic                       bank_return_instr,
  input  wire logic                       bank_trap_return_instr,
  input  wire logic                       svc_ack,
  output logic                            svc_req,
  output logic [15:0]                     svc_vector,
  output logic                            svc_ctx_switch,
  output logic [2:0]                      svc_bank,
  output logic                            core_hold,
  output logic                            restore_req,
  output logic [2:0]                      restore_bank,
  // vector table read, data one cycle after the strobe
  output logic                            vt_rd,
  output logic [15:0]                     vt_addr,
  input  wire logic [7:0]                 vt_data,
  // macro mover
  input  wire logic                       xfer_done,
  output logic                            xfer_req,
  output logic [isc_pkg::IDX_W-1:0]       xfer_idx,
  output logic                            xfer_wide
);

  localparam int N = isc_pkg::NSRC;
  localparam int W = isc_pkg::IDX_W;

  // local aliases of the sequencer states
  localparam isc_pkg::isc_state_e ISC_IDLE  = isc_pkg::ISC_IDLE;
  localparam isc_pkg::isc_state_e ISC_FETCH = isc_pkg::ISC_FETCH;
  localparam isc_pkg::isc_state_e ISC_BANK  = isc_pkg::ISC_BANK;
  localparam isc_pkg::isc_state_e ISC_WAIT  = isc_pkg::ISC_WAIT;
  localparam isc_pkg::isc_state_e ISC_MACRO = isc_pkg::ISC_MACRO;

  // pin synchronisers: third stage only feeds the edge detector
  logic [isc_pkg::NPIN-1:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_s3_reg;
  logic [isc_pkg::NPIN-1:0] pin_rise;
  assign pin_raw  = {timer_event_input, ext_pin_irq, nmi_pin};
  assign pin_rise = pin_s2_reg & ~pin_s3_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // hardware request sets in default priority order
  logic [N-1:0] hw_set;
  assign hw_set[0]    = timer0_overflow_irq;
  assign hw_set[4:1]  = pin_rise[isc_pkg::PIN_EXT +: 4];
  assign hw_set[5]    = pin_rise[isc_pkg::PIN_EXT+4] | capture_x0_match_irq;
  assign hw_set[6]    = pin_rise[isc_pkg::PIN_EXT+5] | capture_01_match_irq;
  assign hw_set[7]    = pin_rise[isc_pkg::PIN_EXT+6]
                      | pin_rise[isc_pkg::PIN_TI];
  assign hw_set[13:8] = compare_match_irq;
  assign hw_set[14]   = uart_rx_done_irq;
  assign hw_set[15]   = uart_tx_done_irq;
  assign hw_set[16]   = sync_serial_done_irq;
  assign hw_set[17]   = converter_done_irq;

  // per-source state
  logic [N-1:0]              flag_reg, mask_reg, macro_reg, cse_reg, wide_reg;
  logic [isc_pkg::LVL_W-1:0] lvl_reg [N];
  logic [isc_pkg::CNT_W-1:0] cnt_reg [N];
  logic [N*isc_pkg::LVL_W-1:0] lvl_flat;
  logic [isc_pkg::DATA_W-1:0] ctrl_word [N];

  // service sequencer state
  isc_pkg::isc_state_e state_reg, state_next;
  logic [W-1:0] cur_idx_reg;
  logic         cur_mask_reg;
  logic         reset_pend_reg, nmi_pend_reg, wdt_pend_reg;
  logic         brk_pend_reg, trap_pend_reg, bsw_pend_reg;
  logic [2:0]   bsw_bank_reg, int_bank_reg, trap_bank_reg;
  logic         err_reg;

  // address decode
  logic         ctrl_hit, cnt_hit, stat_hit;
  logic [W-1:0] ctrl_sel, cnt_sel;
  assign ctrl_sel = W'(addr - isc_pkg::CTRL_BASE);
  assign cnt_sel  = W'(addr - isc_pkg::COUNT_BASE);
  assign ctrl_hit = (addr >= isc_pkg::CTRL_BASE)
                  && (addr < isc_pkg::CTRL_BASE + 8'(N));
  assign cnt_hit  = (addr >= isc_pkg::COUNT_BASE)
                  && (addr < isc_pkg::COUNT_BASE + 8'(N));
  assign stat_hit = (addr == isc_pkg::STATUS_ADDR);

  // priority resolution over serviceable sources
  logic [N-1:0] eligible;
  logic         win_found;
  logic [W-1:0] win_idx;
  assign eligible = flag_reg & ~mask_reg
                  & (macro_reg | {N{core_int_enable}});

  isc_prio u_prio (
    .req   (eligible),
    .lvl   (lvl_flat),
    .found (win_found),
    .idx   (win_idx)
  );

  // macro mover
  logic mac_start, mac_done;
  assign mac_start = (state_reg == ISC_IDLE) && (state_next == ISC_MACRO);

  isc_macro u_macro (
    .clk        (clk),
    .rst_n      (rst_n),
    .start      (mac_start),
    .start_idx  (win_idx),
    .start_wide (wide_reg[win_idx]),
    .xfer_done  (xfer_done),
    .xfer_req   (xfer_req),
    .xfer_idx   (xfer_idx),
    .xfer_wide  (xfer_wide),
    .done       (mac_done)
  );

  // completion events of the current maskable service
  logic ack_mask, mac_last;
  assign ack_mask = (state_reg == ISC_WAIT) & svc_ack & cur_mask_reg;
  assign mac_last = mac_done & (cnt_reg[cur_idx_reg] == isc_pkg::CNT_LAST);

  // per-source registers; hardware set beats every clear
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      logic wr_c, wr_n, hit_cur, clr;
      assign wr_c    = wr & ctrl_hit & (ctrl_sel == W'(g));
      assign wr_n    = wr & cnt_hit & (cnt_sel == W'(g));
      assign hit_cur = (cur_idx_reg == W'(g));
      assign clr     = (wr_c & ~wdata[isc_pkg::FLAG_BIT])
                     | (ack_mask & hit_cur)
                     | (mac_done & hit_cur & ~mac_last);
      assign lvl_flat[g*isc_pkg::LVL_W +: isc_pkg::LVL_W] = lvl_reg[g];
      assign ctrl_word[g] = {1'b0, wide_reg[g], lvl_reg[g], cse_reg[g],
                             macro_reg[g], mask_reg[g], flag_reg[g]};

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          flag_reg[g]  <= 1'b0;
          mask_reg[g]  <= isc_pkg::MASK_RST;
          macro_reg[g] <= 1'b0;
          cse_reg[g]   <= 1'b0;
          wide_reg[g]  <= 1'b0;
          lvl_reg[g]   <= isc_pkg::LVL_RST;
          cnt_reg[g]   <= isc_pkg::CNT_RST;
        end else begin
          flag_reg[g] <= hw_set[g] | (wr_c & wdata[isc_pkg::FLAG_BIT])
                       | (flag_reg[g] & ~clr);
          if (wr_c) begin
            mask_reg[g]  <= wdata[isc_pkg::MASK_BIT];
            macro_reg[g] <= wdata[isc_pkg::MACRO_BIT];
            cse_reg[g]   <= wdata[isc_pkg::CSE_BIT];
            wide_reg[g]  <= wdata[isc_pkg::WIDE_BIT];
            lvl_reg[g]   <= wdata[isc_pkg::LVL_LSB +: isc_pkg::LVL_W];
          end else if (mac_last && hit_cur) begin
            macro_reg[g] <= 1'b0;   // flag kept, now vectored
          end
          if (wr_n) begin
            cnt_reg[g] <= wdata;
          end else if (mac_done && hit_cur) begin
            cnt_reg[g] <= cnt_reg[g] - isc_pkg::CNT_LAST;
          end
        end
      end
    end
  endgenerate

  // fixed order: reset, nmi, watchdog, software, then maskable
  logic        pick_fixed, pick_cs, pick_mask;
  logic [15:0] pick_vec;
  assign pick_fixed = reset_pend_reg | nmi_pend_reg | wdt_pend_reg
                    | brk_pend_reg | trap_pend_reg | bsw_pend_reg;
  assign pick_mask  = ~pick_fixed & win_found;
  assign pick_cs    = pick_mask & cse_reg[win_idx] & ~macro_reg[win_idx];
  assign pick_vec   = reset_pend_reg ? isc_pkg::VEC_RESET :
                      nmi_pend_reg   ? isc_pkg::VEC_NMI :
                      wdt_pend_reg   ? isc_pkg::VEC_WDT :
                      brk_pend_reg   ? isc_pkg::VEC_BRK :
                      trap_pend_reg  ? isc_pkg::VEC_TRAP :
                      bsw_pend_reg   ? isc_pkg::VEC_RESET :
                      isc_pkg::isc_vector(win_idx);

  // sequencer transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ISC_IDLE: begin
        if (pick_fixed) begin
          state_next = ISC_WAIT;
        end else if (pick_mask && macro_reg[win_idx]) begin
          state_next = ISC_MACRO;
        end else if (pick_cs) begin
          state_next = ISC_FETCH;
        end else if (pick_mask) begin
          state_next = ISC_WAIT;
        end
      end
      ISC_FETCH: state_next = ISC_BANK;
      ISC_BANK:  state_next = ISC_WAIT;
      ISC_WAIT:  if (svc_ack) state_next = ISC_IDLE;
      ISC_MACRO: if (mac_done) state_next = ISC_IDLE;
      default:   state_next = ISC_IDLE;
    endcase
  end

  // whether the idle decision serves a fixed source, and when that service is acked
  logic take;
  assign take = (state_reg == ISC_IDLE) & pick_fixed;
  logic done_fixed;
  assign done_fixed = (state_reg == ISC_WAIT) & svc_ack & ~cur_mask_reg;

  // outputs to the core
  logic        svc_req_reg, svc_cs_reg, hold_reg, vt_rd_reg, rst_req_reg;
  logic [15:0] svc_vec_reg, vt_addr_reg;
  logic [2:0]  svc_bank_reg, rst_bank_reg;
  logic [isc_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg    <= ISC_IDLE;
      cur_idx_reg  <= '0;
      cur_mask_reg <= 1'b0;
      svc_req_reg  <= 1'b0;
      svc_cs_reg   <= 1'b0;
      svc_vec_reg  <= isc_pkg::VEC_RESET;
      svc_bank_reg <= '0;
      vt_rd_reg    <= 1'b0;
      vt_addr_reg  <= isc_pkg::VEC_RESET;
      hold_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      vt_rd_reg <= (state_next == ISC_FETCH);
      hold_reg  <= (state_next == ISC_MACRO);
      svc_req_reg <= (state_next == ISC_WAIT);
      if (state_reg == ISC_IDLE && state_next != ISC_IDLE) begin
        cur_idx_reg  <= win_idx;
        cur_mask_reg <= ~pick_fixed;
        svc_vec_reg  <= pick_vec;
        vt_addr_reg  <= pick_vec;
        svc_cs_reg   <= bsw_pend_reg & ~(reset_pend_reg | nmi_pend_reg
                      | wdt_pend_reg | brk_pend_reg | trap_pend_reg);
        svc_bank_reg <= bsw_bank_reg;
      end else if (state_reg == ISC_BANK) begin
        svc_cs_reg   <= 1'b1;
        svc_bank_reg <= vt_data[2:0];
      end
    end
  end

  // fixed pendings: request beats the acknowledge that clears it
  logic bsw_win;
  assign bsw_win = done_fixed & svc_cs_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_pend_reg <= 1'b1;
      nmi_pend_reg   <= 1'b0;
      wdt_pend_reg   <= 1'b0;
      brk_pend_reg   <= 1'b0;
      trap_pend_reg  <= 1'b0;
      bsw_pend_reg   <= 1'b0;
      bsw_bank_reg   <= '0;
    end else begin
      reset_pend_reg <= reset_pend_reg & ~(done_fixed
                        && svc_vec_reg == isc_pkg::VEC_RESET && !svc_cs_reg);
      nmi_pend_reg   <= pin_rise[isc_pkg::PIN_NMI] | (nmi_pend_reg
                        & ~(done_fixed && svc_vec_reg == isc_pkg::VEC_NMI));
      wdt_pend_reg   <= watchdog_irq | (wdt_pend_reg
                        & ~(done_fixed && svc_vec_reg == isc_pkg::VEC_WDT));
      brk_pend_reg   <= software_break_instr | (brk_pend_reg
                        & ~(done_fixed && svc_vec_reg == isc_pkg::VEC_BRK));
      trap_pend_reg  <= opcode_trap | (trap_pend_reg
                        & ~(done_fixed && svc_vec_reg == isc_pkg::VEC_TRAP));
      bsw_pend_reg   <= bank_switch_trap_instr | (bsw_pend_reg & ~bsw_win);
      if (bank_switch_trap_instr) begin
        bsw_bank_reg <= bank_trap_imm;
      end
    end
  end

  // banks in use for the two kinds of return
  logic ack_cs;
  assign ack_cs = (state_reg == ISC_WAIT) & svc_ack & svc_cs_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_bank_reg  <= '0;
      trap_bank_reg <= '0;
      rst_req_reg   <= 1'b0;
      rst_bank_reg  <= '0;
    end else begin
      if (ack_cs && cur_mask_reg) int_bank_reg <= svc_bank_reg;
      if (ack_cs && !cur_mask_reg) trap_bank_reg <= svc_bank_reg;
      rst_req_reg <= bank_return_instr | bank_trap_return_instr;
      if (bank_trap_return_instr) begin
        rst_bank_reg <= trap_bank_reg;
      end else if (bank_return_instr) begin
        rst_bank_reg <= int_bank_reg;
      end
    end
  end

  // register read path, data the cycle after the strobe
  logic clr_err;
  logic [isc_pkg::DATA_W-1:0] stat_word, rd_mux;
  assign clr_err   = wr & stat_hit & wdata[isc_pkg::ST_ERR_BIT];
  assign stat_word = {hold_reg, (state_reg != ISC_IDLE), err_reg, cur_idx_reg};
  assign rd_mux    = ctrl_hit ? ctrl_word[ctrl_sel] :
                     cnt_hit  ? cnt_reg[cnt_sel] :
                     stat_hit ? stat_word : '0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
      err_reg   <= 1'b0;
    end else begin
      rdata_reg <= rd ? rd_mux : '0;
      err_reg   <= uart_rx_error_signal | (err_reg & ~clr_err);
    end
  end

  assign rdata          = rdata_reg;
  assign svc_req        = svc_req_reg;
  assign svc_vector     = svc_vec_reg;
  assign svc_ctx_switch = svc_cs_reg;
  assign svc_bank       = svc_bank_reg;
  assign core_hold      = hold_reg;
  assign restore_req    = rst_req_reg;
  assign restore_bank   = rst_bank_reg;
  assign vt_rd          = vt_rd_reg;
  assign vt_addr        = vt_addr_reg;

endmodule : isc_ctrl
`default_nettype wire

// File: verilog/isc_macro.sv
`timescale 1ns/100ps
`default_nettype none
// hardware mover handshake: one sfr/memory transfer per start
module isc_macro (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic [isc_pkg::IDX_W-1:0] start_idx,
  input  wire logic                     start_wide,
  input  wire logic                     xfer_done,
  output logic                          xfer_req,
  output logic [isc_pkg::IDX_W-1:0]     xfer_idx,
  output logic                          xfer_wide,
  output logic                          done
);

  logic                      xfer_req_reg;
  logic [isc_pkg::IDX_W-1:0] xfer_idx_reg;
  logic                      xfer_wide_reg;
  logic                      done_reg;

  // request stands until the mover reports completion
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_req_reg  <= 1'b0;
      xfer_idx_reg  <= '0;
      xfer_wide_reg <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      done_reg <= xfer_req_reg & xfer_done;
      if (start) begin
        xfer_req_reg  <= 1'b1;
        xfer_idx_reg  <= start_idx;
        xfer_wide_reg <= start_wide; // one or two bytes
      end else if (xfer_done) begin
        xfer_req_reg  <= 1'b0;
      end
    end
  end

  assign xfer_req  = xfer_req_reg;
  assign xfer_idx  = xfer_idx_reg;
  assign xfer_wide = xfer_wide_reg;
  assign done      = done_reg;

endmodule : isc_macro
`default_nettype wire

// File: verilog/isc_pkg.sv
package isc_pkg;

  // sizes of the source table and the register port
  localparam int NSRC   = 18;
  localparam int IDX_W  = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;
  localparam int LVL_W  = 2;
  localparam int NPIN   = 9;

  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] CTRL_BASE   = 8'h00;
  localparam logic [7:0] COUNT_BASE  = 8'h20;
  localparam logic [7:0] STATUS_ADDR = 8'h60;

  // per-source control word layout
  localparam int FLAG_BIT  = 0;
  localparam int MASK_BIT  = 1;
  localparam int MACRO_BIT = 2;
  localparam int CSE_BIT   = 3;
  localparam int LVL_LSB   = 4;
  localparam int WIDE_BIT  = 6;

  // status word layout
  localparam int ST_ERR_BIT  = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_HOLD_BIT = 7;

  // values after reset, priority scan start level, last macro count
  localparam logic             MASK_RST  = 1'b1;
  localparam logic [LVL_W-1:0] LVL_RST   = 2'h2;
  localparam logic [LVL_W-1:0] LVL_LOW   = 2'h2;
  localparam logic [CNT_W-1:0] CNT_RST   = 8'h00;
  localparam logic [CNT_W-1:0] CNT_LAST  = 8'h01;

  // vector table entries
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_NMI     = 16'h0002;
  localparam logic [15:0] VEC_WDT     = 16'h0004;
  localparam logic [15:0] VEC_MASK0   = 16'h0006;
  localparam logic [15:0] VEC_SERIAL  = 16'h0024;
  localparam logic [15:0] VEC_TRAP    = 16'h003C;
  localparam logic [15:0] VEC_BRK     = 16'h003E;
  localparam logic [IDX_W-1:0] SERIAL_IDX = 5'h0E;

  // pin positions in the synchronised pin bus
  localparam int PIN_NMI = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_TI  = 8;

  typedef enum logic [2:0] {
    ISC_IDLE, ISC_FETCH, ISC_BANK, ISC_WAIT, ISC_MACRO
  } isc_state_e;

  // serial entries skip one slot after the compare group
  function automatic logic [15:0] isc_vector(input logic [IDX_W-1:0] idx);
    if (idx < SERIAL_IDX) begin
      isc_vector = VEC_MASK0 + {10'h000, idx, 1'b0};
    end else begin
      isc_vector = VEC_SERIAL + {10'h000, idx - SERIAL_IDX, 1'b0};
    end
  endfunction : isc_vector

endpackage : isc_pkg

// File: verilog/isc_prio.sv
`timescale 1ns/100ps
`default_nettype none
// picks the pending source with the best programmable level, then the
// smallest default priority number within that level
module isc_prio (
  input  wire logic [isc_pkg::NSRC-1:0]              req,
  input  wire logic [isc_pkg::NSRC*isc_pkg::LVL_W-1:0] lvl,
  output logic                                       found,
  output logic [isc_pkg::IDX_W-1:0]                  idx
);

  logic [isc_pkg::LVL_W-1:0] best_lvl;

  // descending scan lets the lowest index overwrite at equal level
  always_comb begin
    found    = 1'b0;
    idx      = '0;
    best_lvl = isc_pkg::LVL_LOW;
    for (int i = isc_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i] && (!found ||
          lvl[i*isc_pkg::LVL_W +: isc_pkg::LVL_W] <= best_lvl)) begin
        found    = 1'b1;
        idx      = i[isc_pkg::IDX_W-1:0];
        best_lvl = lvl[i*isc_pkg::LVL_W +: isc_pkg::LVL_W];
      end
    end
  end

endmodule : isc_prio
`default_nettype wire
